// ===== rtl/pid_seq_pkg.sv
package pid_seq_pkg;
    // Data widths
    localparam int PCT_W  = 16;          // Percent in 0.01 % steps
    localparam int FREQ_W = 16;          // Frequency in 0.01 Hz steps
    localparam int TIME_W = 16;          // Delay settings in 0.1 s steps
    localparam int TICK_W = 21;          // Prescaler width

    // One percent scale: 100 % reads as this value
    localparam logic [PCT_W-1:0] PCT_FULL = 16'h2710;

    // Time base of the delay settings
    localparam int CLK_HZ          = 20000000;
    localparam int TIME_UNIT_MS    = 100;
    localparam int TICK_CYCLES     = CLK_HZ / 1000 * TIME_UNIT_MS;

    // Wake comparison codes
    localparam logic [1:0] WAKE_BELOW  = 2'h0;
    localparam logic [1:0] WAKE_ABOVE  = 2'h1;
    localparam logic [1:0] WAKE_BEYOND = 2'h2;

    // Frequency source selection codes
    localparam logic [1:0] SRC_NONE   = 2'h0;
    localparam logic [1:0] SRC_PRERUN = 2'h1;
    localparam logic [1:0] SRC_PID    = 2'h2;
    localparam logic [1:0] SRC_OPEN   = 2'h3;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_PRERUN = 6'h02,
        ST_PID    = 6'h04,
        ST_SLEEP  = 6'h08,
        ST_OPEN   = 6'h10,
        ST_TRIP   = 6'h20
    } seq_state_t;
endpackage

// ===== rtl/interval_timer.sv
// Counts whole time units while a condition holds; restarts when broken
module interval_timer (
    input  wire logic                           clk_sys,   // System clock
    input  wire logic                           reset_n,   // Sync reset
    input  wire logic                           clk_en,    // Freeze when low
    input  wire logic                           tick,      // Time unit pulse
    input  wire logic                           cond,      // Qualifying level
    input  wire logic [pid_seq_pkg::TIME_W-1:0] limit,     // Units to wait
    output logic                                expired    // Held interval
);
    typedef struct packed {
        logic [pid_seq_pkg::TIME_W-1:0] count;  // Elapsed units
        logic                           done;   // Interval complete
    } tmr_t;

    tmr_t st_reg;   // Registered state
    tmr_t st_next;  // Next state

    // Count up while held; any break clears the count
    always_comb begin
        st_next = st_reg;
        if (!cond) begin
            st_next.count = '0;
            st_next.done  = 1'b0;
        end else if (st_reg.count >= limit) begin
            st_next.done = 1'b1;
        end else if (tick) begin
            st_next.count = st_reg.count + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.done;
endmodule

// ===== rtl/pid_prerun_sleep_sequencer.sv
// Overview of operation
// - Run command with prerun: hold fixed open-loop frequency
// - Feedback above exit level hands over to PID
// - Feedback low for whole timeout: trip, stop
// - Frequency below sleep level for delay: sleep
// - Sleep stops output; frequency, delay set separately
// - Mode 0: wake when feedback below level
// - Mode 1: wake when feedback above level
// - Mode 2: wake when reference-feedback gap exceeds level
// - Bypass terminal on: stop PID, run open-loop
// - Bypass terminal off: restart PID operation
// - Open-loop percent converts to frequency, 100% maximum
module pid_prerun_sleep_sequencer (
    input  wire logic                           clk_sys,             // Clock
    input  wire logic                           reset_n,             // Reset
    input  wire logic                           clk_en,              // Enable
    input  wire logic                           run_cmd,             // Run
    input  wire logic                           fault_clear,         // Reset trip
    input  wire logic                           prerun_enable,       // Use prerun
    input  wire logic [pid_seq_pkg::FREQ_W-1:0] prerun_frequency,    // Prerun Hz
    input  wire logic [pid_seq_pkg::PCT_W-1:0]  prerun_exit_level,   // Exit %
    input  wire logic [pid_seq_pkg::TIME_W-1:0] prerun_fail_timeout, // Units
    input  wire logic [pid_seq_pkg::TIME_W-1:0] sleep_delay_time,    // Units
    input  wire logic [pid_seq_pkg::FREQ_W-1:0] sleep_frequency,     // Sleep Hz
    input  wire logic [pid_seq_pkg::PCT_W-1:0]  wake_level,          // Wake %
    input  wire logic [1:0]                     wake_compare_mode,   // 0..2
    input  wire logic [pid_seq_pkg::FREQ_W-1:0] maximum_frequency,   // 100 %
    input  wire logic [pid_seq_pkg::PCT_W-1:0]  pid_reference,       // Ref %
    input  wire logic [pid_seq_pkg::PCT_W-1:0]  pid_feedback,        // Fbk %
    input  wire logic [pid_seq_pkg::FREQ_W-1:0] output_frequency,    // Now Hz
    input  wire logic                           loop_bypass_request, // Pin
    output logic [1:0]                          freq_source,         // Select
    output logic [pid_seq_pkg::FREQ_W-1:0]      open_loop_freq,      // Hz
    output logic                                output_running,      // Drive on
    output logic                                sleeping,            // Asleep
    output logic                                prerun_trip          // Fault
);
    typedef struct packed {
        pid_seq_pkg::seq_state_t         state;     // Sequencer state
        logic [pid_seq_pkg::TICK_W-1:0]  prescale;  // Time unit divider
        logic                            tick;      // Time unit pulse
        logic                            pin_meta;  // Sync stage one
        logic                            pin_sync;  // Sync stage two
        logic [1:0]                      src;       // Frequency source
        logic [pid_seq_pkg::FREQ_W-1:0]  olf;       // Open-loop frequency
        logic                            run;       // Output running
        logic                            slp;       // Asleep
        logic                            trip;      // Trip flag
    } seq_t;

    seq_t st_reg;   // Registered state
    seq_t st_next;  // Next state

    logic prerun_low;     // Feedback not yet above exit level
    logic freq_low;       // Output below sleep frequency
    logic prerun_expired; // Prerun timeout reached
    logic sleep_expired;  // Sleep delay reached
    logic wake_now;       // Wake condition met

    // Percent to frequency, 100 % equals the maximum frequency
    function automatic logic [pid_seq_pkg::FREQ_W-1:0] pct_to_freq(
        input logic [pid_seq_pkg::PCT_W-1:0]  pct,
        input logic [pid_seq_pkg::FREQ_W-1:0] fmax
    );
        logic [31:0] prod;
        prod = 32'(pct) * 32'(fmax);
        return pid_seq_pkg::FREQ_W'(prod / 32'(pid_seq_pkg::PCT_FULL));
    endfunction

    // Absolute difference of two percentages
    function automatic logic [pid_seq_pkg::PCT_W-1:0] abs_diff(
        input logic [pid_seq_pkg::PCT_W-1:0] a,
        input logic [pid_seq_pkg::PCT_W-1:0] b
    );
        return (a > b) ? (a - b) : (b - a);
    endfunction

    // Only feedback at or below the exit level keeps the timeout running
    assign prerun_low = (pid_feedback <= prerun_exit_level);
    assign freq_low   = (output_frequency < sleep_frequency);

    // Wake comparison per selected mode; unused code never wakes
    always_comb begin
        unique case (wake_compare_mode)
            pid_seq_pkg::WAKE_BELOW:
                wake_now = (pid_feedback < wake_level);
            pid_seq_pkg::WAKE_ABOVE:
                wake_now = (pid_feedback > wake_level);
            pid_seq_pkg::WAKE_BEYOND:
                wake_now = (abs_diff(pid_reference, pid_feedback)
                            > wake_level);
            default:
                wake_now = 1'b0;
        endcase
    end

    // Prerun failure timer, runs only in prerun state
    interval_timer u_prerun_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .tick    (st_reg.tick),
        .cond    (prerun_low &&
                  st_reg.state == pid_seq_pkg::ST_PRERUN),
        .limit   (prerun_fail_timeout),
        .expired (prerun_expired)
    );

    // Sleep delay timer, runs only during PID operation
    interval_timer u_sleep_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .tick    (st_reg.tick),
        .cond    (freq_low && st_reg.state == pid_seq_pkg::ST_PID),
        .limit   (sleep_delay_time),
        .expired (sleep_expired)
    );

    // Sequencer next state and outputs
    always_comb begin
        st_next = st_reg;

        // Bypass pin comes from outside; two stages before use
        st_next.pin_meta = loop_bypass_request;
        st_next.pin_sync = st_reg.pin_meta;

        // Time unit prescaler
        st_next.tick = 1'b0;
        if (st_reg.prescale ==
            pid_seq_pkg::TICK_W'(pid_seq_pkg::TICK_CYCLES - 1)) begin
            st_next.prescale = '0;
            st_next.tick     = 1'b1;
        end else begin
            st_next.prescale = st_reg.prescale + 1'b1;
        end

        unique case (st_reg.state)
            pid_seq_pkg::ST_IDLE: begin
                if (run_cmd) begin
                    if (st_reg.pin_sync) begin
                        st_next.state = pid_seq_pkg::ST_OPEN;
                    end else if (prerun_enable) begin
                        st_next.state = pid_seq_pkg::ST_PRERUN;
                    end else begin
                        st_next.state = pid_seq_pkg::ST_PID;
                    end
                end
            end
            pid_seq_pkg::ST_PRERUN: begin
                if (!run_cmd) begin
                    st_next.state = pid_seq_pkg::ST_IDLE;
                end else if (st_reg.pin_sync) begin
                    st_next.state = pid_seq_pkg::ST_OPEN;
                end else if (!prerun_low) begin
                    st_next.state = pid_seq_pkg::ST_PID;
                end else if (prerun_expired) begin
                    st_next.state = pid_seq_pkg::ST_TRIP;
                end
            end
            pid_seq_pkg::ST_PID: begin
                if (!run_cmd) begin
                    st_next.state = pid_seq_pkg::ST_IDLE;
                end else if (st_reg.pin_sync) begin
                    st_next.state = pid_seq_pkg::ST_OPEN;
                end else if (sleep_expired) begin
                    st_next.state = pid_seq_pkg::ST_SLEEP;
                end
            end
            pid_seq_pkg::ST_SLEEP: begin
                if (!run_cmd) begin
                    st_next.state = pid_seq_pkg::ST_IDLE;
                end else if (st_reg.pin_sync) begin
                    st_next.state = pid_seq_pkg::ST_OPEN;
                end else if (wake_now) begin
                    st_next.state = pid_seq_pkg::ST_PID;
                end
            end
            pid_seq_pkg::ST_OPEN: begin
                if (!run_cmd) begin
                    st_next.state = pid_seq_pkg::ST_IDLE;
                end else if (!st_reg.pin_sync) begin
                    st_next.state = pid_seq_pkg::ST_PID;
                end
            end
            pid_seq_pkg::ST_TRIP: begin
                // Trip holds until cleared with run removed
                if (fault_clear && !run_cmd) begin
                    st_next.state = pid_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next.state = pid_seq_pkg::ST_IDLE;
            end
        endcase

        // Outputs registered from the next state
        st_next.run  = 1'b0;
        st_next.slp  = 1'b0;
        st_next.trip = 1'b0;
        st_next.src  = pid_seq_pkg::SRC_NONE;
        st_next.olf  = '0;
        unique case (st_next.state)
            pid_seq_pkg::ST_PRERUN: begin
                // Fixed frequency, PID output ignored
                st_next.run = 1'b1;
                st_next.src = pid_seq_pkg::SRC_PRERUN;
                st_next.olf = prerun_frequency;
            end
            pid_seq_pkg::ST_PID: begin
                st_next.run = 1'b1;
                st_next.src = pid_seq_pkg::SRC_PID;
            end
            pid_seq_pkg::ST_SLEEP: begin
                st_next.slp = 1'b1;
            end
            pid_seq_pkg::ST_OPEN: begin
                // Reference taken as percent of maximum frequency
                st_next.run = 1'b1;
                st_next.src = pid_seq_pkg::SRC_OPEN;
                st_next.olf = pct_to_freq(pid_reference,
                                          maximum_frequency);
            end
            pid_seq_pkg::ST_TRIP: begin
                st_next.trip = 1'b1;
            end
            default: begin
                st_next.run = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_reg       <= '0;
            st_reg.state <= pid_seq_pkg::ST_IDLE;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign freq_source    = st_reg.src;
    assign open_loop_freq = st_reg.olf;
    assign output_running = st_reg.run;
    assign sleeping       = st_reg.slp;
    assign prerun_trip    = st_reg.trip;
endmodule

// ===== tb/pid_seq_sensor.sv
// Far side: feedback sensor and the bypass terminal
module pid_seq_sensor (
    input  wire logic        clk_sys,             // Clock
    output logic [15:0]      pid_feedback,        // Reading
    output logic             loop_bypass_request  // Terminal
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet sensor, terminal off at power-up
    initial begin
        pid_feedback = 16'h0000;
        loop_bypass_request = 1'b0;
    end
    // New reading, held until the next one
    task automatic sense(input logic [15:0] value);
        pid_feedback = value;
    endtask
    // Terminal level, held long enough to pass the synchroniser
    task automatic press(input logic on);
        loop_bypass_request = on;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule

// ===== tb/pid_seq_chk.sv
// Port-level checks of the sequencer
module pid_seq_chk (
    input wire logic        clk_sys,             // Clock
    input wire logic        reset_n,             // Reset
    input wire logic        clk_en,              // Enable
    input wire logic        run_cmd,             // Run
    input wire logic [15:0] prerun_frequency,    // Prerun Hz
    input wire logic [15:0] prerun_exit_level,   // Exit
    input wire logic [15:0] prerun_fail_timeout, // Units
    input wire logic [15:0] sleep_delay_time,    // Units
    input wire logic [15:0] sleep_frequency,     // Sleep Hz
    input wire logic [15:0] wake_level,          // Wake
    input wire logic [1:0]  wake_compare_mode,   // Mode
    input wire logic [15:0] maximum_frequency,   // Full
    input wire logic [15:0] pid_reference,       // Ref
    input wire logic [15:0] pid_feedback,        // Fbk
    input wire logic [15:0] output_frequency,    // Now Hz
    input wire logic        loop_bypass_request, // Pin
    input wire logic [1:0]  freq_source,         // Select
    input wire logic [15:0] open_loop_freq,      // Hz
    input wire logic        output_running,      // Drive on
    input wire logic        sleeping,            // Asleep
    input wire logic        prerun_trip          // Fault
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [2:0]  hist_reg; // Last terminal samples
    logic [15:0] gap;      // Reference-feedback distance
    logic        wake_hit; // Wake test for the mode
    logic        live;     // Running, terminal settled low
    logic [31:0] scaled;   // Expected open-loop value
    // Ones at reset, so nothing counts as settled too early
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hist_reg <= 3'h7;
        end else begin
            hist_reg <= {hist_reg[1:0], loop_bypass_request};
        end
    end
    // Conditions derived from the inputs
    always_comb begin
        gap = (pid_reference > pid_feedback) ? pid_reference - pid_feedback
                                             : pid_feedback - pid_reference;
        wake_hit = (wake_compare_mode == pid_seq_pkg::WAKE_BELOW
                    && pid_feedback < wake_level)
                || (wake_compare_mode == pid_seq_pkg::WAKE_ABOVE
                    && pid_feedback > wake_level)
                || (wake_compare_mode == pid_seq_pkg::WAKE_BEYOND
                    && gap > wake_level);
        live = run_cmd && clk_en && hist_reg == 3'h0 && !loop_bypass_request;
        scaled = 32'(pid_reference) * 32'(maximum_frequency)
               / 32'(pid_seq_pkg::PCT_FULL);
    end
    property p_prerun_hold;
        freq_source == pid_seq_pkg::SRC_PRERUN |->
            open_loop_freq == prerun_frequency && output_running;
    endproperty
    a_prerun_hold: assert property (p_prerun_hold)
        else $error("prerun output wrong");
    property p_prerun_exit;
        freq_source == pid_seq_pkg::SRC_PRERUN
            && pid_feedback > prerun_exit_level && live
            |=> freq_source == pid_seq_pkg::SRC_PID;
    endproperty
    a_prerun_exit: assert property (p_prerun_exit)
        else $error("prerun did not hand over");
    property p_prerun_fail;
        freq_source == pid_seq_pkg::SRC_PRERUN && live
            && pid_feedback <= prerun_exit_level && prerun_fail_timeout == 0
            |-> ##[1:6] (prerun_trip && !output_running
                         && freq_source == pid_seq_pkg::SRC_NONE);
    endproperty
    a_prerun_fail: assert property (p_prerun_fail)
        else $error("prerun trip missing");
    property p_sleep_entry;
        freq_source == pid_seq_pkg::SRC_PID && live && !wake_hit
            && output_frequency < sleep_frequency && sleep_delay_time == 0
            |-> ##[1:6] sleeping;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");
    property p_sleep_off;
        sleeping |-> !output_running && freq_source == pid_seq_pkg::SRC_NONE;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("output on while asleep");
    property p_wake;
        sleeping && wake_hit && live
            |=> !sleeping && freq_source == pid_seq_pkg::SRC_PID;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake missed");
    property p_bypass_on;
        loop_bypass_request && output_running && run_cmd && clk_en
            |-> ##[1:4] freq_source == pid_seq_pkg::SRC_OPEN;
    endproperty
    a_bypass_on: assert property (p_bypass_on)
        else $error("open loop not taken");
    property p_bypass_off;
        freq_source == pid_seq_pkg::SRC_OPEN && !loop_bypass_request
            && run_cmd && clk_en
            |-> ##[1:4] freq_source == pid_seq_pkg::SRC_PID;
    endproperty
    a_bypass_off: assert property (p_bypass_off)
        else $error("loop not restarted");
    property p_scale;
        freq_source == pid_seq_pkg::SRC_OPEN
            && $past(freq_source) == pid_seq_pkg::SRC_OPEN
            && $stable(pid_reference) && $stable(maximum_frequency)
            |-> open_loop_freq == scaled[15:0];
    endproperty
    a_scale: assert property (p_scale)
        else $error("open-loop frequency wrong");
endmodule
bind pid_prerun_sleep_sequencer pid_seq_chk chk (.*);

// ===== tb/pid_prerun_sleep_sequencer_test.sv
// Sequence tests of the sequencer at its ports
module pid_prerun_sleep_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 4000; // Ceiling on run length
    localparam logic [4:0] S_IDLE = 5'h00;
    localparam logic [4:0] S_PRE = {pid_seq_pkg::SRC_PRERUN, 3'h4};
    localparam logic [4:0] S_PID = {pid_seq_pkg::SRC_PID, 3'h4};
    localparam logic [4:0] S_SLP = 5'h02;
    localparam logic [4:0] S_OPEN = {pid_seq_pkg::SRC_OPEN, 3'h4};
    localparam logic [4:0] S_TRIP = 5'h01;
    logic        clk_sys, reset_n, clk_en, run_cmd;         // Control
    logic        fault_clear, prerun_enable;                // Control
    logic [15:0] prerun_frequency, prerun_exit_level;       // Prerun
    logic [15:0] prerun_fail_timeout, sleep_delay_time;     // Delays
    logic [15:0] sleep_frequency, wake_level;               // Levels
    logic [15:0] maximum_frequency, pid_reference;          // Scale
    logic [15:0] pid_feedback, output_frequency;            // Process
    logic [1:0]  wake_compare_mode, freq_source;            // Codes
    logic        loop_bypass_request, output_running;       // Pin, drive
    logic        sleeping, prerun_trip;                     // Status
    logic [15:0] open_loop_freq;                            // Hz out
    logic [31:0] prod;                                      // Expected
    logic [15:0] nw [3] = '{16'h1770, 16'h0fa0, 16'h1770};  // Stay asleep
    logic [15:0] wk [3] = '{16'h0fa0, 16'h1770, 16'h0000};  // Wake
    int          mismatches = 0, checks = 0, cycles = 0;    // Tallies
    wire logic [4:0] seen = {freq_source, output_running, sleeping,
                             prerun_trip};
    pid_prerun_sleep_sequencer dut (.*);
    pid_seq_sensor sensor (.*);
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Hang guard ends the run as a failure
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            summarize();
        end
    end
    // Step n edges, then settle past the edge
    task automatic go(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic st(input logic [4:0] exp);
        chk("state", 16'(exp), 16'(seen));
    endtask
    task automatic summarize();
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        {reset_n, run_cmd, fault_clear} = 3'h0;
        {clk_en, prerun_enable} = 2'h3;
        prerun_frequency = 16'h0bb8;
        prerun_exit_level = 16'h1388;
        prerun_fail_timeout = 16'h0005;
        sleep_delay_time = 16'h0000;
        sleep_frequency = 16'h07d0;
        wake_level = 16'h1388;
        wake_compare_mode = 2'h3;
        maximum_frequency = 16'h1770;
        pid_reference = 16'h1770;
        output_frequency = 16'h0fa0;
        go(20);
        reset_n = 1'b1;
        go(1);
        st(S_IDLE);
        // Prerun holds until feedback is strictly above the exit level
        sensor.sense(16'h03e8);
        run_cmd = 1'b1;
        go(2);
        st(S_PRE);
        chk("open_loop_freq", 16'h0bb8, open_loop_freq);
        sensor.sense(16'h1388);
        go(3);
        st(S_PRE);
        sensor.sense(16'h1389);
        go(1);
        st(S_PID);
        // Low output frequency sleeps; each mode wakes on its own test
        output_frequency = 16'h0064;
        sensor.sense(16'h1770);
        go(8);
        st(S_SLP);
        for (int i = 0; i < 3; i++) begin
            wake_compare_mode = 2'(i);
            sensor.sense(nw[i]);
            go(3);
            st(S_SLP);
            sensor.sense(wk[i]);
            output_frequency = 16'h0fa0;
            go(1);
            st(S_PID);
            wake_compare_mode = 2'h3;
            output_frequency = 16'h0064;
            go(8);
            st(S_SLP);
        end
        // Mode 1 needs feedback above the level to wake
        wake_compare_mode = 2'h1;
        output_frequency = 16'h0fa0;
        sensor.sense(16'h1770);
        go(2);
        st(S_PID);
        // Bypass terminal: open loop on scaled reference, then back
        pid_reference = 16'h1388;
        prod = 32'(pid_reference) * 32'(maximum_frequency);
        prod = prod / 32'(pid_seq_pkg::PCT_FULL);
        sensor.press(1'b1);
        go(2);
        st(S_OPEN);
        chk("open_loop_freq", prod[15:0], open_loop_freq);
        // Full scale follows the maximum frequency setting
        maximum_frequency = 16'h2710;
        go(1);
        chk("open_loop_freq", 16'h1388, open_loop_freq);
        sensor.press(1'b0);
        go(2);
        st(S_PID);
        // Prerun with feedback stuck low trips; clear needs run off
        run_cmd = 1'b0;
        go(2);
        st(S_IDLE);
        prerun_fail_timeout = 16'h0000;
        sensor.sense(16'h03e8);
        run_cmd = 1'b1;
        go(8);
        st(S_TRIP);
        fault_clear = 1'b1;
        go(2);
        st(S_TRIP);
        run_cmd = 1'b0;
        go(2);
        st(S_IDLE);
        fault_clear = 1'b0;
        // Without prerun a run command starts the loop at once
        prerun_enable = 1'b0;
        run_cmd = 1'b1;
        go(2);
        st(S_PID);
        // Low enable freezes the sleep timer and the sequencer
        clk_en = 1'b0;
        output_frequency = 16'h0064;
        go(4);
        st(S_PID);
        clk_en = 1'b1;
        go(3);
        st(S_SLP);
        // Removing the run command leaves sleep
        run_cmd = 1'b0;
        go(2);
        st(S_IDLE);
        summarize();
    end
endmodule
